//--- hw/slcpc_core.sv
// Serializer link core: symbol packing, scrambling, sync filter, bridge steering, power control.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - One 35-bit symbol each pixel clock while running.
// - Symbol carries video, syncs, control, audio.
// - Payload scrambled before sending.
// - Pixel clock between 5 and 96 MHz.
// - Reverse channel carries GPIO in low four shift bits.
// - Reverse rate chosen from medium and mode.
// - Display mode forwards local slave transactions.
// - Camera mode replays remote transactions locally.
// - Bridge supports multi-master arbitration.
// - Filtered syncs: two transitions, three-clock minimum.
// - Unfiltered syncs: two transitions, no minimum.
// - Frame sync: one change, 130-clock pulses.
// - Filter suppresses glitches on line sync and pixel valid.
// - Low power-down input powers device down.
// - Auto power-down enabled by config bit.
// - No reverse channel enters reduced power.
// - Active reverse channel triggers wake attempt.
// - Forward channel restarts only after bit cleared.
// - Clock-loss sleep when enabled and clock slow.
// - Re-lock when pixel clock returns.
// - Configuration kept during clock-loss sleep.
// - Lock about 131 pixel clocks after power-up.
module slcpc_core (
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	input wire logic pclk_in,
	input wire logic chip_power_enable_n_in,
	input wire logic [23:0] video_in,
	input wire logic line_sync_in,
	input wire logic frame_sync_in,
	input wire logic pixel_valid_in,
	input wire logic sync_filter_en_in,
	input wire logic [3:0] ctrl_payload_in,
	input wire logic [1:0] audio_payload_in,
	input wire logic rapd_en_in,
	input wire logic pclk_sleep_en_in,
	input wire logic twisted_pair_medium_in,
	input wire logic high_freq_mode_in,
	input wire logic camera_mode_in,
	input wire logic slow_reverse_channel_in,
	input wire logic local_bus_busy_in,
	input wire logic remote_bus_busy_in,
	output logic [34:0] fast_forward_channel_out,
	output logic sym_valid_out,
	output logic link_locked_out,
	output logic rapd_sleep_out,
	output logic pclk_lost_out,
	output logic powered_down_out,
	output logic rc_active_out,
	output logic rc_fast_rate_out,
	output logic bridge_to_remote_out,
	output logic bridge_to_local_out,
	output logic bridge_grant_out,
	output logic [3:0] rc_gpio_out
);
	logic rst_s1;
	logic rst_s;
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_s1 <= 1'b0;
			rst_s <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_s <= rst_s1;
		end
	end
	// Two-flop synchronisers for every pin input except rapd_en_in, pclk_sleep_en_in, local_bus_busy_in and remote_bus_busy_in.
	localparam int NS = 40;
	logic [NS-1:0] pin_s1;
	logic [NS-1:0] pin_s2;
	wire [NS-1:0] pin_raw = {pclk_in, chip_power_enable_n_in, video_in, line_sync_in,
		frame_sync_in, pixel_valid_in, sync_filter_en_in, ctrl_payload_in,
		audio_payload_in, slow_reverse_channel_in, twisted_pair_medium_in,
		high_freq_mode_in, camera_mode_in};
	always_ff @(posedge sys_clk_in or negedge rst_s) begin
		if (!rst_s) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
		end
	end
	wire pclk_s = pin_s2[39];
	wire pwr_n_s = pin_s2[38];
	wire [23:0] vid_s = pin_s2[37:14];
	wire ls_s = pin_s2[13];
	wire fs_s = pin_s2[12];
	wire pv_s = pin_s2[11];
	wire filt_en_s = pin_s2[10];
	wire [3:0] ctl_s = pin_s2[9:6];
	wire [1:0] aud_s = pin_s2[5:4];
	wire rc_s = pin_s2[3];
	wire stp_s = pin_s2[2];
	wire hf_s = pin_s2[1];
	wire cam_s = pin_s2[0];
	logic pclk_d;
	always_ff @(posedge sys_clk_in or negedge rst_s) begin
		if (!rst_s) pclk_d <= 1'b0;
		else pclk_d <= pclk_s;
	end
	wire pclk_rise = pclk_s & ~pclk_d;
	logic [15:0] loss_cnt;
	wire loss_now = (loss_cnt >= 16'(slcpc_pkg::LOSS_CYC));
	always_ff @(posedge sys_clk_in or negedge rst_s) begin
		if (!rst_s) loss_cnt <= '0;
		else if (pclk_rise) loss_cnt <= '0;
		else if (!loss_now) loss_cnt <= loss_cnt + 16'h0001;
	end
	// Reverse-channel bit period from medium and mode.
	wire rc_fast = stp_s & hf_s;
	wire [7:0] rc_bit_cyc = rc_fast ? 8'(slcpc_pkg::RC_HF_CYC) : 8'(slcpc_pkg::RC_COAX_CYC);
	// Reverse channel declared gone after a long quiet time.
	logic rc_d;
	logic [15:0] rc_quiet;
	wire rc_edge = rc_s ^ rc_d;
	wire rc_gone = (rc_quiet >= 16'(slcpc_pkg::RC_LOSS_BITS) * {8'h00, rc_bit_cyc});
	always_ff @(posedge sys_clk_in or negedge rst_s) begin
		if (!rst_s) begin
			rc_d <= 1'b0;
			rc_quiet <= 16'hffff;
		end else begin
			rc_d <= rc_s;
			if (rc_edge) rc_quiet <= '0;
			else if (!rc_gone) rc_quiet <= rc_quiet + 16'h0001;
		end
	end
	// Reverse bits sampled mid-bit into a shift register; low four are GPIO.
	logic [7:0] rc_phase;
	logic [7:0] rc_shift;
	wire rc_sample = (rc_phase == {1'b0, rc_bit_cyc[7:1]});
	always_ff @(posedge sys_clk_in or negedge rst_s) begin
		if (!rst_s) begin
			rc_phase <= '0;
			rc_shift <= '0;
		end else begin
			rc_phase <= (rc_edge || rc_phase == rc_bit_cyc - 8'h01) ? 8'h00 : rc_phase + 8'h01;
			if (rc_sample) rc_shift <= {rc_shift[6:0], rc_s};
		end
	end
	// Three-clock stable filter on line sync and pixel valid.
	logic [1:0] st_cnt [2];
	logic [1:0] filt;
	wire [1:0] raw_lp = {ls_s, pv_s};
	// Frame sync held for a full window before a change.
	logic fs_out;
	logic [7:0] fs_cnt;
	// Window transition budget for line sync and pixel valid.
	logic [7:0] win_cnt;
	logic [1:0] tr_cnt [2];
	logic [1:0] lp_out;
	wire win_end = (win_cnt == 8'(slcpc_pkg::WIN_PCLKS - 1));
	always_ff @(posedge sys_clk_in or negedge rst_s) begin
		if (!rst_s) begin
			filt <= '0;
			lp_out <= '0;
			win_cnt <= '0;
			fs_out <= 1'b0;
			fs_cnt <= '0;
			for (int i = 0; i < 2; i++) begin
				st_cnt[i] <= '0;
				tr_cnt[i] <= '0;
			end
		end else if (pclk_rise) begin
			win_cnt <= win_end ? 8'h00 : win_cnt + 8'h01;
			if (fs_cnt != 8'(slcpc_pkg::WIN_PCLKS)) fs_cnt <= fs_cnt + 8'h01;
			if (fs_s != fs_out && fs_cnt == 8'(slcpc_pkg::WIN_PCLKS)) begin
				fs_out <= fs_s;
				fs_cnt <= '0;
			end
			for (int i = 0; i < 2; i++) begin
				// Glitches shorter than the minimum never reach filt.
				if (raw_lp[i] == filt[i]) st_cnt[i] <= '0;
				else if (st_cnt[i] == 2'(slcpc_pkg::MIN_PULSE - 1)) begin
					filt[i] <= raw_lp[i];
					st_cnt[i] <= '0;
				end else st_cnt[i] <= st_cnt[i] + 2'h1;
				// Budget applies with or without the filter.
				if ((filt_en_s ? filt[i] : raw_lp[i]) != lp_out[i] &&
					tr_cnt[i] < 2'(slcpc_pkg::LS_MAX_TR)) begin
					lp_out[i] <= filt_en_s ? filt[i] : raw_lp[i];
					tr_cnt[i] <= win_end ? 2'h0 : tr_cnt[i] + 2'h1;
				end else if (win_end) tr_cnt[i] <= '0;
			end
		end
	end
	// Bridge direction from mode; yield while the other side holds the bus.
	wire grant = ~(cam_s ? local_bus_busy_in : remote_bus_busy_in);
	// Power and lock sequencing.
	slcpc_pkg::slcpc_state_t st;
	slcpc_pkg::slcpc_state_t next_st;
	logic [7:0] lock_cnt;
	logic sleep_rapd;
	wire lock_done = (lock_cnt == 8'(slcpc_pkg::LOCK_PCLKS));
	// Sleep keeps loss and reverse monitors running; wake on clock return, after remote sleep also needing reverse channel and a cleared enable.
	always_comb begin
		next_st = st;
		unique case (st)
			slcpc_pkg::SLCPC_OFF: if (pwr_n_s) next_st = slcpc_pkg::SLCPC_LOCK;
			slcpc_pkg::SLCPC_LOCK: if (lock_done) next_st = slcpc_pkg::SLCPC_RUN;
			slcpc_pkg::SLCPC_RUN: begin
				if ((pclk_sleep_en_in && loss_now) || (rapd_en_in && rc_gone))
					next_st = slcpc_pkg::SLCPC_SLEEP;
			end
			slcpc_pkg::SLCPC_SLEEP: begin
				// Wake needs clock; after remote sleep also reverse channel and a cleared enable.
				if (!loss_now && (!sleep_rapd || (!rc_gone && !rapd_en_in)))
					next_st = slcpc_pkg::SLCPC_LOCK;
			end
		endcase
		if (!pwr_n_s) next_st = slcpc_pkg::SLCPC_OFF;
	end
	// Additive scrambler, LFSR advanced once per symbol.
	logic [34:0] lfsr;
	wire [34:0] lfsr_next = {lfsr[33:0], lfsr[34] ^ lfsr[32]};
	wire [34:0] payload = {2'b00, aud_s, ctl_s, fs_out, lp_out, vid_s};
	wire sym_fire = pclk_rise && st == slcpc_pkg::SLCPC_RUN;
	// No configuration is stored here; sleep clears nothing held outside.
	always_ff @(posedge sys_clk_in or negedge rst_s) begin
		if (!rst_s) begin
			st <= slcpc_pkg::SLCPC_OFF;
			lock_cnt <= '0;
			sleep_rapd <= 1'b0;
			lfsr <= slcpc_pkg::SCR_SEED;
			fast_forward_channel_out <= slcpc_pkg::IDLE_SYM;
			sym_valid_out <= 1'b0;
			link_locked_out <= 1'b0;
			rapd_sleep_out <= 1'b0;
			pclk_lost_out <= 1'b0;
			powered_down_out <= 1'b1;
			rc_active_out <= 1'b0;
			rc_fast_rate_out <= 1'b0;
			bridge_to_remote_out <= 1'b0;
			bridge_to_local_out <= 1'b0;
			bridge_grant_out <= 1'b0;
			rc_gpio_out <= '0;
		end else begin
			st <= next_st;
			// Lock counts pixel clocks after power-up or wake.
			if (st != slcpc_pkg::SLCPC_LOCK) lock_cnt <= '0;
			else if (pclk_rise && !lock_done) lock_cnt <= lock_cnt + 8'h01;
			if (st == slcpc_pkg::SLCPC_RUN && next_st == slcpc_pkg::SLCPC_SLEEP)
				sleep_rapd <= rapd_en_in && rc_gone;
			// One symbol per pixel clock rising edge while running; idle when not running.
			if (sym_fire) begin
				lfsr <= lfsr_next;
				fast_forward_channel_out <= payload ^ lfsr;
			end else if (st != slcpc_pkg::SLCPC_RUN) begin
				fast_forward_channel_out <= slcpc_pkg::IDLE_SYM;
			end
			sym_valid_out <= sym_fire;
			link_locked_out <= (st == slcpc_pkg::SLCPC_RUN);
			rapd_sleep_out <= (st == slcpc_pkg::SLCPC_SLEEP) && sleep_rapd;
			pclk_lost_out <= loss_now;
			powered_down_out <= (st == slcpc_pkg::SLCPC_OFF);
			rc_active_out <= !rc_gone;
			rc_fast_rate_out <= rc_fast;
			bridge_to_remote_out <= !cam_s && st == slcpc_pkg::SLCPC_RUN;
			bridge_to_local_out <= cam_s && st == slcpc_pkg::SLCPC_RUN;
			bridge_grant_out <= grant;
			rc_gpio_out <= rc_shift[3:0];
		end
	end
	symbol_locked_a: assert property (@(posedge sys_clk_in) disable iff (!rst_s)
		sym_valid_out |-> $past(st) == slcpc_pkg::SLCPC_RUN)
		else $error("symbol sent while not running");
	pin_power_down_a: assert property (@(posedge sys_clk_in) disable iff (!rst_s)
		!pwr_n_s |=> st == slcpc_pkg::SLCPC_OFF)
		else $error("power-down pin ignored");
	// Lock takes the pixel clock count.
	lock_count_a: assert property (@(posedge sys_clk_in) disable iff (!rst_s)
		$rose(link_locked_out) |-> $past(lock_cnt, 2) == 8'(slcpc_pkg::LOCK_PCLKS))
		else $error("lock left early");
	// Frame sync held for a full window.
	frame_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_s)
		(pclk_rise && fs_cnt != 8'(slcpc_pkg::WIN_PCLKS)) |=> $stable(fs_out))
		else $error("frame sync changed too soon");
	// No restart from remote sleep while enable set.
	rapd_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_s)
		(st == slcpc_pkg::SLCPC_SLEEP && sleep_rapd && rapd_en_in) |=>
		st != slcpc_pkg::SLCPC_LOCK)
		else $error("woke with enable set");
	sleep_idle_a: assert property (@(posedge sys_clk_in) disable iff (!rst_s)
		(st == slcpc_pkg::SLCPC_SLEEP) [*2] |-> fast_forward_channel_out == slcpc_pkg::IDLE_SYM)
		else $error("output not idle in sleep");
	loss_sleep_a: assert property (@(posedge sys_clk_in) disable iff (!rst_s)
		(st == slcpc_pkg::SLCPC_RUN && pclk_sleep_en_in && loss_now && pwr_n_s) |=>
		st == slcpc_pkg::SLCPC_SLEEP)
		else $error("clock loss not handled");
	// Filtered level changes only after a steady run.
	filter_steady_a: assert property (@(posedge sys_clk_in) disable iff (!rst_s)
		(pclk_rise && st_cnt[0] != 2'(slcpc_pkg::MIN_PULSE - 1)) |=> filt[0] == $past(filt[0]))
		else $error("filter changed too soon");
	tr_budget_a: assert property (@(posedge sys_clk_in) disable iff (!rst_s)
		tr_cnt[0] <= 2'(slcpc_pkg::LS_MAX_TR) && tr_cnt[1] <= 2'(slcpc_pkg::LS_MAX_TR))
		else $error("transition budget exceeded");
endmodule : slcpc_core
`default_nettype wire

//--- hw/slcpc_pkg.sv
// Shared constants for the serializer link core and power control block.
package slcpc_pkg;
	localparam int SYM_BITS = 35;
	localparam int VID_BITS = 24;
	localparam int GPIO_BITS = 4;
	localparam int CLK_MHZ = 250;
	localparam int PCLK_MIN_MHZ = 5;
	localparam int PCLK_MAX_MHZ = 96;
	localparam int LOSS_MHZ = 1;
	localparam int LOSS_CYC = CLK_MHZ / LOSS_MHZ;
	localparam int LOCK_PCLKS = 131;
	localparam int WIN_PCLKS = 130;
	localparam int LS_MAX_TR = 2;
	localparam int MIN_PULSE = 3;
	localparam int RC_COAX_KBPS = 3100;
	localparam int RC_STP_HF_KBPS = 4400;
	localparam int RC_COAX_CYC = (CLK_MHZ * 1000) / RC_COAX_KBPS;
	localparam int RC_HF_CYC = (CLK_MHZ * 1000) / RC_STP_HF_KBPS;
	localparam int RC_LOSS_BITS = 16;
	localparam logic [34:0] SCR_SEED = 35'h5a5a5a5a5;
	localparam logic [34:0] IDLE_SYM = 35'h000000000;
	localparam int CFG_RAPD_BIT = 7;
	localparam int CFG_PCLK_SLEEP_BIT = 1;
	typedef enum logic [1:0] {SLCPC_OFF, SLCPC_LOCK, SLCPC_RUN, SLCPC_SLEEP} slcpc_state_t;
endpackage : slcpc_pkg

//--- tb/slcpc_far_model.sv
// Far-end deserializer model: descrambles symbols and drives the reverse line.
`timescale 1ns/1ps
`default_nettype none
module slcpc_far_model (
	input wire logic sys_clk_in,
	input wire logic [34:0] sym_in,
	input wire logic sym_valid_in,
	input wire logic locked_in,
	input wire logic rc_on_in,
	output logic [34:0] payload_out,
	output logic strobe_out,
	output logic rc_out
);
	logic [34:0] lfsr = slcpc_pkg::SCR_SEED;
	int bt = 0;
	initial begin
		payload_out = 35'h0;
		strobe_out = 1'b0;
		rc_out = 1'b0;
	end
	always @(posedge sys_clk_in) begin
		strobe_out <= sym_valid_in & locked_in;
		if (sym_valid_in) begin
			payload_out <= sym_in ^ lfsr;
			lfsr <= {lfsr[33:0], lfsr[34] ^ lfsr[32]};
		end
	end
	always @(posedge sys_clk_in) begin
		bt <= (bt == slcpc_pkg::RC_COAX_CYC - 1) ? 0 : bt + 1;
		if (!rc_on_in) begin
			rc_out <= 1'b0;
		end else if (bt == 0) begin
			rc_out <= ~rc_out;
		end
	end
endmodule : slcpc_far_model
`default_nettype wire

//--- tb/tb_slcpc_core.sv
// Self-checking bench for the serializer link core.
`timescale 1ns/1ps
`default_nettype none
module tb_slcpc_core;
	logic sys_clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic pclk_in = 1'b0;
	logic pclk_run = 1'b0;
	logic chip_power_enable_n = 1'b0;
	logic [23:0] vid = 24'h0;
	logic [3:0] ctrl = 4'h0;
	logic [1:0] aud = 2'h0;
	logic ls = 1'b0, fs = 1'b0, pv = 1'b0, filt = 1'b1, rapd = 1'b0, pslp = 1'b0;
	logic tp = 1'b0, hf = 1'b0, cam = 1'b0, lbusy = 1'b0, rbusy = 1'b0, rc_on = 1'b1;
	logic rnd_on = 1'b0, cmp_on = 1'b0, seen_ls = 1'b0, strobe, rc, vld, lck, rsl, lost, pd;
	logic rca, fast, to_rem, to_loc, grant;
	logic [34:0] ffc, pay;
	logic [3:0] gpio;
	logic [31:0] seed = 32'h4e57231a;
	int mismatches = 0, comparisons = 0, cycles = 0, rises = 0, syms = 0, s0, r0;
	slcpc_core u_slcpc_core (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .pclk_in(pclk_in),
		.chip_power_enable_n_in(chip_power_enable_n), .video_in(vid), .line_sync_in(ls),
		.frame_sync_in(fs), .pixel_valid_in(pv), .sync_filter_en_in(filt),
		.ctrl_payload_in(ctrl), .audio_payload_in(aud), .rapd_en_in(rapd),
		.pclk_sleep_en_in(pslp), .twisted_pair_medium_in(tp), .high_freq_mode_in(hf),
		.camera_mode_in(cam), .slow_reverse_channel_in(rc), .local_bus_busy_in(lbusy),
		.remote_bus_busy_in(rbusy), .fast_forward_channel_out(ffc), .sym_valid_out(vld),
		.link_locked_out(lck), .rapd_sleep_out(rsl), .pclk_lost_out(lost),
		.powered_down_out(pd), .rc_active_out(rca), .rc_fast_rate_out(fast),
		.bridge_to_remote_out(to_rem), .bridge_to_local_out(to_loc),
		.bridge_grant_out(grant), .rc_gpio_out(gpio));
	slcpc_far_model u_slcpc_far_model (.sys_clk_in(sys_clk_in), .sym_in(ffc),
		.sym_valid_in(vld), .locked_in(lck), .rc_on_in(rc_on), .payload_out(pay),
		.strobe_out(strobe), .rc_out(rc));
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	task check(input logic [34:0] seen, input logic [34:0] exp, input string m);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask : check
	task complete_run;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : complete_run
	task cyc(input int n);
		repeat (n) @(negedge sys_clk_in);
	endtask : cyc
	task wait_lock;
		int n;
		n = 0;
		r0 = rises;
		while (lck !== 1'b1 && n < 9000) begin
			cyc(1);
			n++;
		end
		check({34'h0, rises - r0 >= 131 && rises - r0 <= 133}, 35'h1, "lock time");
	endtask : wait_lock
	task pulse(input int n);
		@(negedge pclk_in);
		@(negedge sys_clk_in);
		ls = 1'b1;
		seen_ls = 1'b0;
		repeat (n) @(negedge pclk_in);
		@(negedge sys_clk_in);
		ls = 1'b0;
		repeat (8) @(negedge pclk_in);
	endtask : pulse
	always #2 sys_clk_in = ~sys_clk_in;
	initial begin
		#7;
		forever begin
			#80;
			if (pclk_run) pclk_in = ~pclk_in;
		end
	end
	always @(posedge pclk_in) rises++;
	always @(posedge sys_clk_in) begin
		cycles++;
		if (cycles == 60000) begin
			mismatches++;
			complete_run();
		end
	end
	always @(negedge pclk_in) if (rnd_on) begin
		@(negedge sys_clk_in);
		seed = lfsr_next(seed);
		{aud, ctrl, vid} = seed[29:0];
	end
	always @(negedge sys_clk_in) if (strobe) begin
		syms++;
		seen_ls = seen_ls | pay[25];
		if (cmp_on) check(pay, {2'b00, aud, ctrl, fs, ls, pv, vid}, "payload");
	end
	initial begin
		cyc(20);
		rst_b_in = 1'b1;
		cyc(4);
		check({34'h0, pd}, 35'h1, "held down");
		// power pin released once supplies settle
		pclk_run = 1'b1;
		rnd_on = 1'b1;
		cyc(8);
		chip_power_enable_n = 1'b1;
		wait_lock();
		check({34'h0, pd}, 35'h0, "powered");
		$display("test lock done");
		@(negedge pclk_in);
		s0 = syms;
		r0 = rises;
		cmp_on = 1'b1;
		repeat (40) @(negedge pclk_in);
		cmp_on = 1'b0;
		check(35'(syms - s0), 35'(rises - r0), "symbol count");
		$display("test data done");
		pulse(1);
		check({34'h0, seen_ls}, 35'h0, "glitch passed");
		pulse(2);
		check({34'h0, seen_ls}, 35'h0, "two-clock pulse passed");
		repeat (131) @(negedge pclk_in);
		pulse(6);
		check({34'h0, seen_ls}, 35'h1, "pulse lost");
		repeat (131) @(negedge pclk_in);
		filt = 1'b0;
		pulse(1);
		check({34'h0, seen_ls}, 35'h1, "short pulse lost");
		filt = 1'b1;
		$display("test filter done");
		for (int i = 0; i < 4; i++) begin
			{tp, hf} = 2'(i);
			cyc(8);
			check({34'h0, fast}, {34'h0, i == 3}, "rate");
		end
		for (int i = 0; i < 8; i++) begin
			{cam, lbusy, rbusy} = 3'(i);
			cyc(8);
			check({32'h0, to_rem, to_loc, grant}, {32'h0, !cam, cam, cam ? !lbusy : !rbusy}, "bridge");
		end
		{tp, hf, cam, lbusy, rbusy} = 5'h0;
		check({34'h0, rca}, 35'h1, "reverse seen");
		$display("test bridge done");
		pslp = 1'b1;
		pclk_run = 1'b0;
		cyc(400);
		check({32'h0, lost, lck, 1'b0}, 35'h4, "clock loss");
		check(ffc, 35'h0, "idle in sleep");
		pclk_run = 1'b1;
		wait_lock();
		check({34'h0, lost}, 35'h0, "relock");
		pslp = 1'b0;
		$display("test clock loss done");
		rapd = 1'b1;
		rc_on = 1'b0;
		cyc(16 * slcpc_pkg::RC_COAX_CYC + 200);
		check({32'h0, rsl, rca, 1'b0}, 35'h4, "remote sleep");
		check(ffc, 35'h0, "idle in remote sleep");
		rc_on = 1'b1;
		cyc(400);
		check({32'h0, rsl, rca, 1'b0}, 35'h6, "still asleep");
		check(ffc, 35'h0, "no restart");
		check({34'h0, gpio == 4'h5 || gpio == 4'ha}, 35'h1, "gpio bits");
		// enable bit cleared with reverse active
		rapd = 1'b0;
		wait_lock();
		check({34'h0, rsl}, 35'h0, "awake");
		@(negedge pclk_in);
		cmp_on = 1'b1;
		repeat (20) @(negedge pclk_in);
		cmp_on = 1'b0;
		$display("test remote sleep done");
		chip_power_enable_n = 1'b0;
		cyc(8);
		check({32'h0, pd, lck, 1'b0}, 35'h4, "power down");
		check(ffc, 35'h0, "idle when down");
		$display("test power down done");
		complete_run();
	end
endmodule : tb_slcpc_core
`default_nettype wire
